// ==== pgt_masks.sv ====
// power-good tree mask registers and the two gated power-good outputs
//
// Contract
// RULE1 - Bits 7..4 of the output-two aux mask drop control inputs five, four, two, one when set.
// RULE2 - Bits 3..0 of the output-two aux mask drop termination, shared rail, switch one, reg three.
// RULE3 - Bit 2 of each aux mask covers one shared source chosen by the factory strap.
// RULE4 - The output-three main mask covers reg A2, switch A1 and step-downs six to one.
// RULE5 - Bits 7..4 of the output-three aux mask make control input levels ignored when set.
// RULE6 - Bits 3..0 of the output-three aux mask make rail good flags ignored when set.
// RULE7 - All bits of the three mask registers are read and written by software.
// RULE8 - An output is good only when every unmasked source is good; masked ones do not matter.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "pgt_defs.svh"

module pgt_masks #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [3:0] ctrl_level_in,
  input wire logic [5:0] stepdown_good_in,
  input wire logic load_switch_a_good_in,
  input wire logic regulator2_good_in,
  input wire logic termination_good_in,
  input wire logic load_switch1_good_in,
  input wire logic regulator3_good_in,
  input wire logic load_switch2_good_in,
  input wire logic regulator_a1_good_in,
  input wire logic shared_sel_strap_in,
  output logic good_output_two_out,
  output logic good_output_three_out
);
  import pgt_pkg::*;

  // elaboration refuses an address bus too narrow to reach the mask offsets
  if (ADDR_W < 8) begin : g_addr_w_check
    $error("pgt_masks: ADDR_W must be at least 8");
  end

  logic rst_meta_n;
  logic rst_n;
  pgt_state_t s;
  pgt_state_t next_s;
  logic shared_good;
  logic [7:0] aux_src;
  logic [7:0] main_src;

  // reset enters asynchronously, leaves synchronously
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // a set mask bit forces its source to read as good
  function automatic logic tree_good(input logic [7:0] mask, input logic [7:0] src);
    tree_good = &(src | mask);
  endfunction : tree_good

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction : hit

  // true for the three mask offsets only
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, `PGT_OUT2_AUX_OFS) || hit(a, `PGT_OUT3_MAIN_OFS)
             || hit(a, `PGT_OUT3_AUX_OFS);
  endfunction : mapped

  // exactly one source of an eight-bit group reports bad
  function automatic logic lone_bad(input logic [7:0] grp, input int idx);
    lone_bad = (grp == ~(8'h01 << idx));
  endfunction : lone_bad

  always_comb begin
    shared_good = s.shared_is_reg_a1 ? regulator_a1_good_in : load_switch2_good_in; // [RULE3]
    aux_src = {ctrl_level_in[3], ctrl_level_in[2], ctrl_level_in[1], ctrl_level_in[0],
               termination_good_in, shared_good, load_switch1_good_in, regulator3_good_in};
    main_src = {regulator2_good_in, load_switch_a_good_in, stepdown_good_in};
  end

  always_comb begin
    next_s = s;
    // strap is sampled once, on the first edge after reset release
    if (!s.strap_taken) begin
      next_s.shared_is_reg_a1 = shared_sel_strap_in; // [RULE3]
      next_s.strap_taken = 1'b1;
    end
    if (wr_in) begin
      if (hit(addr_in, `PGT_OUT2_AUX_OFS)) begin
        next_s.out2_good_aux_mask = wdata_in; // [RULE7]
      end
      if (hit(addr_in, `PGT_OUT3_MAIN_OFS)) begin
        next_s.out3_good_main_mask = wdata_in; // [RULE7]
      end
      if (hit(addr_in, `PGT_OUT3_AUX_OFS)) begin
        next_s.out3_good_aux_mask = wdata_in; // [RULE7]
      end
    end
    // read data stands only in the cycle after the strobe; unmapped reads give zero
    next_s.rdata = `PGT_RDATA_IDLE;
    if (rd_in) begin
      if (hit(addr_in, `PGT_OUT2_AUX_OFS)) begin
        next_s.rdata = s.out2_good_aux_mask; // [RULE7]
      end else if (hit(addr_in, `PGT_OUT3_MAIN_OFS)) begin
        next_s.rdata = s.out3_good_main_mask; // [RULE7]
      end else if (hit(addr_in, `PGT_OUT3_AUX_OFS)) begin
        next_s.rdata = s.out3_good_aux_mask; // [RULE7]
      end
    end
    // output two: control inputs and aux rails only [RULE1] [RULE2] [RULE8]
    next_s.good_two = tree_good(s.out2_good_aux_mask, aux_src);
    // output three: main rails and aux sources together [RULE4] [RULE5] [RULE6] [RULE8]
    next_s.good_three = tree_good(s.out3_good_main_mask, main_src)
                        && tree_good(s.out3_good_aux_mask, aux_src);
  end

  // outputs stay low through reset so nothing reads as good before the masks settle
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s.out2_good_aux_mask <= `PGT_MASK_RST;
      s.out3_good_main_mask <= `PGT_MASK_RST;
      s.out3_good_aux_mask <= `PGT_MASK_RST;
      s.rdata <= `PGT_RDATA_IDLE;
      s.shared_is_reg_a1 <= 1'b0;
      s.strap_taken <= 1'b0;
      s.good_two <= 1'b0;
      s.good_three <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_out = s.rdata;
  assign good_output_two_out = s.good_two;
  assign good_output_three_out = s.good_three;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr_out2(logic [7:0] d);
    wr_in && hit(addr_in, `PGT_OUT2_AUX_OFS) && wdata_in == d;
  endsequence

  sequence s_rd_out2;
    rd_in && !wr_in && hit(addr_in, `PGT_OUT2_AUX_OFS);
  endsequence

  a_out2_ctrl_low: assert property ( // [RULE1]
    (s.out2_good_aux_mask[`PGT_CTRL_MSB:`PGT_CTRL_LSB] == 4'h0 && ctrl_level_in != 4'hF)
      |=> !good_output_two_out)
    else $error("unmasked low control input did not pull output two low");

  a_out2_rail_low: assert property ( // [RULE2]
    (s.out2_good_aux_mask[`PGT_RAIL_MSB:`PGT_RAIL_LSB] == 4'h0 && !termination_good_in)
      |=> !good_output_two_out)
    else $error("unmasked termination rail did not pull output two low");

  a_shared_source_pick: assert property ( // [RULE3]
    (s.strap_taken && s.shared_is_reg_a1 && !s.out2_good_aux_mask[`PGT_SHARED_BIT]
      && !regulator_a1_good_in) |=> !good_output_two_out)
    else $error("shared source select not honoured");

  a_out3_main_low: assert property ( // [RULE4]
    (s.out3_good_main_mask == `PGT_MASK_RST && !regulator2_good_in) |=> !good_output_three_out)
    else $error("unmasked main rail did not pull output three low");

  a_out3_ctrl_ignored: assert property ( // [RULE5]
    (s.out3_good_aux_mask[`PGT_CTRL_MSB:`PGT_CTRL_LSB] == 4'hF
      && s.out3_good_aux_mask[`PGT_RAIL_MSB:`PGT_RAIL_LSB] == 4'hF
      && s.out3_good_main_mask == `PGT_ALL_ONES) |=> good_output_three_out)
    else $error("fully masked output three not good");

  a_out3_rail_low: assert property ( // [RULE6]
    (s.out3_good_aux_mask[`PGT_RAIL_MSB:`PGT_RAIL_LSB] == 4'h0 && !regulator3_good_in)
      |=> !good_output_three_out)
    else $error("unmasked regulator three did not pull output three low");

  a_mask_write_read: assert property ( // [RULE7]
    s_wr_out2(wdata_in) ##1 s_rd_out2 |=> rdata_out == $past(wdata_in, 2))
    else $error("mask readback differs from written value");

  // outputs leave reset one edge after the disable lifts, so wait for the strap flag
  a_all_sources_good: assert property ( // [RULE8]
    (s.strap_taken
      && ctrl_level_in == 4'hF && stepdown_good_in == 6'h3F && load_switch_a_good_in
      && regulator2_good_in && termination_good_in && load_switch1_good_in
      && regulator3_good_in && load_switch2_good_in && regulator_a1_good_in)
      |=> (good_output_two_out && good_output_three_out))
    else $error("all sources good but an output is low");

  a_read_idle_zero: assert property ( // [RULE7]
    !rd_in |=> rdata_out == `PGT_RDATA_IDLE)
    else $error("read data not zero outside a read answer");

  sequence s_wr_at(logic [7:0] ofs);
    wr_in && !rd_in && hit(addr_in, ofs);
  endsequence

  sequence s_rd_at(logic [7:0] ofs);
    rd_in && !wr_in && hit(addr_in, ofs);
  endsequence

  a_out2_write_lands: assert property ( // [RULE7]
    s_wr_at(`PGT_OUT2_AUX_OFS) |=> s.out2_good_aux_mask == $past(wdata_in))
    else $error("write to output two aux mask did not land");

  a_main_write_lands: assert property ( // [RULE7]
    s_wr_at(`PGT_OUT3_MAIN_OFS) |=> s.out3_good_main_mask == $past(wdata_in))
    else $error("write to output three main mask did not land");

  a_aux3_write_lands: assert property ( // [RULE7]
    s_wr_at(`PGT_OUT3_AUX_OFS) |=> s.out3_good_aux_mask == $past(wdata_in))
    else $error("write to output three aux mask did not land");

  a_out2_read_answer: assert property ( // [RULE7]
    s_rd_at(`PGT_OUT2_AUX_OFS) |=> rdata_out == $past(s.out2_good_aux_mask))
    else $error("read of output two aux mask gave a wrong value");

  a_main_read_answer: assert property ( // [RULE7]
    s_rd_at(`PGT_OUT3_MAIN_OFS) |=> rdata_out == $past(s.out3_good_main_mask))
    else $error("read of output three main mask gave a wrong value");

  a_aux3_read_answer: assert property ( // [RULE7]
    s_rd_at(`PGT_OUT3_AUX_OFS) |=> rdata_out == $past(s.out3_good_aux_mask))
    else $error("read of output three aux mask gave a wrong value");

  a_stray_write_ignored: assert property ( // [RULE7]
    (wr_in && !mapped(addr_in)) |=> ($stable(s.out2_good_aux_mask)
      && $stable(s.out3_good_main_mask) && $stable(s.out3_good_aux_mask)))
    else $error("write to an unmapped offset changed a mask");

  a_stray_read_zero: assert property ( // [RULE7]
    (rd_in && !mapped(addr_in)) |=> rdata_out == `PGT_RDATA_IDLE)
    else $error("read of an unmapped offset gave nonzero data");

  a_strap_capture: assert property ( // [RULE3]
    $rose(s.strap_taken) |-> s.shared_is_reg_a1 == $past(shared_sel_strap_in))
    else $error("shared source strap not captured after reset");

  a_strap_held: assert property ( // [RULE3]
    s.strap_taken |=> (s.strap_taken && $stable(s.shared_is_reg_a1)))
    else $error("shared source choice changed after capture");

  a_shared_switch_pick: assert property ( // [RULE3]
    (s.strap_taken && !s.shared_is_reg_a1 && !s.out2_good_aux_mask[`PGT_SHARED_BIT]
      && !load_switch2_good_in) |=> !good_output_two_out)
    else $error("load switch two not used as the shared source");

  // when the strap picks reg A1, load switch two must have no say on output two
  a_unpicked_ignored: assert property ( // [RULE3]
    (s.strap_taken && s.shared_is_reg_a1 && ctrl_level_in == 4'hF && termination_good_in
      && load_switch1_good_in && regulator3_good_in && regulator_a1_good_in
      && !load_switch2_good_in) |=> good_output_two_out)
    else $error("unpicked shared source pulled output two low");

  a_out2_all_masked: assert property ( // [RULE1] [RULE2]
    s.out2_good_aux_mask == `PGT_ALL_ONES |=> good_output_two_out)
    else $error("fully masked output two not good");

  a_out2_aux_only: assert property ( // [RULE8]
    (s.strap_taken && aux_src == `PGT_ALL_ONES) |=> good_output_two_out)
    else $error("output two low although every aux source is good");

  // one lone bad source per bit: its own mask bit alone decides the output
  for (genvar g = 0; g < 8; g++) begin : g_bit_checks
    a_out2_lone_bad: assert property ( // [RULE1] [RULE2] [RULE8]
      lone_bad(aux_src, g) |=> good_output_two_out == $past(s.out2_good_aux_mask[g]))
      else $error("output two ignores the mask bit of a lone bad aux source");

    a_out3_lone_aux: assert property ( // [RULE5] [RULE6] [RULE8]
      (lone_bad(aux_src, g) && main_src == `PGT_ALL_ONES)
        |=> good_output_three_out == $past(s.out3_good_aux_mask[g]))
      else $error("output three ignores the mask bit of a lone bad aux source");

    a_out3_lone_main: assert property ( // [RULE4] [RULE8]
      (lone_bad(main_src, g) && aux_src == `PGT_ALL_ONES)
        |=> good_output_three_out == $past(s.out3_good_main_mask[g]))
      else $error("output three ignores the mask bit of a lone bad main source");
  end

endmodule : pgt_masks
`default_nettype wire

// ==== pgt_defs.svh ====
// register offsets, reset values and field positions of the power-good masks
`ifndef PGT_DEFS_SVH
`define PGT_DEFS_SVH

`define PGT_DATA_W 8
`define PGT_OUT2_AUX_OFS 8'hA9
`define PGT_OUT3_MAIN_OFS 8'hAA
`define PGT_OUT3_AUX_OFS 8'hAB
`define PGT_MASK_RST 8'h00
`define PGT_RDATA_IDLE 8'h00
`define PGT_ALL_ONES 8'hFF

`define PGT_CTRL_MSB 7
`define PGT_CTRL_LSB 4
`define PGT_RAIL_MSB 3
`define PGT_RAIL_LSB 0
`define PGT_SHARED_BIT 2

`endif

// ==== pgt_pkg.sv ====
// types shared by the power-good mask bank
package pgt_pkg;

  typedef struct packed {
    logic [7:0] out2_good_aux_mask;
    logic [7:0] out3_good_main_mask;
    logic [7:0] out3_good_aux_mask;
    logic [7:0] rdata;
    logic shared_is_reg_a1;
    logic strap_taken;
    logic good_two;
    logic good_three;
  } pgt_state_t;

endpackage : pgt_pkg

// ==== pgt_masks_bench.sv ====
// self-checking bench for the power-good mask bank
`timescale 1ns/1ps
`default_nettype none
`include "pgt_defs.svh"
module pgt_masks_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic strap = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [16:0] src = 17'h1_FFFF;
  logic [7:0] rdata;
  logic g2;
  logic g3;
  logic [7:0] m2;
  logic [7:0] m3m;
  logic [7:0] m3a;
  logic [31:0] seed = 32'h0000_7E2B;
  logic [9:0] q[$];
  int mismatches = 0;
  int comparisons = 0;
  initial forever #25 clk = ~clk;
  pgt_masks DUT (.clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ctrl_level_in(src[3:0]),
    .stepdown_good_in(src[16:11]), .load_switch_a_good_in(src[8]),
    .regulator2_good_in(src[7]), .termination_good_in(src[4]), .load_switch1_good_in(src[5]),
    .regulator3_good_in(src[6]), .load_switch2_good_in(src[9]),
    .regulator_a1_good_in(src[10]), .shared_sel_strap_in(strap),
    .good_output_two_out(g2), .good_output_three_out(g3));
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // one edge per call, so no strobe is assigned twice in a time step
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    logic [16:0] s;
    logic [7:0] aux;
    logic [7:0] e;
    seed = xs(seed);
    s = seed[16:0] | seed[31:15];
    seed = xs(seed);
    s = s | seed[16:0];
    aux = {s[3:0], s[4], strap ? s[10] : s[9], s[5], s[6]};
    case (a)
      `PGT_OUT2_AUX_OFS: e = m2;
      `PGT_OUT3_MAIN_OFS: e = m3m;
      `PGT_OUT3_AUX_OFS: e = m3a;
      default: e = 8'h00;
    endcase
    if (r) q.push_back({&(aux | m2), (&(aux | m3a)) & (&({s[7], s[8], s[16:11]} | m3m)), e});
    if (w && a == `PGT_OUT2_AUX_OFS) m2 = d;
    if (w && a == `PGT_OUT3_MAIN_OFS) m3m = d;
    if (w && a == `PGT_OUT3_AUX_OFS) m3a = d;
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    src <= s;
    @(posedge clk);
  endtask : op
  // idle edge first so no read answer is cut by the reset
  task automatic do_reset(input logic sv);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    rst_n <= 1'b0;
    strap <= sv;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    {m2, m3m, m3a} = 24'h00_0000;
    repeat (3) op(1'b0, 1'b0, 8'h00, 8'h00);
  endtask : do_reset
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    logic [9:0] e;
    if (rd_d) begin
      e = q.pop_front();
      check("rdata", rdata, e[7:0]);
      check("good_two", {7'h00, g2}, {7'h00, e[9]});
      check("good_three", {7'h00, g3}, {7'h00, e[8]});
    end else begin
      check("rdata_idle", rdata, `PGT_RDATA_IDLE);
    end
  end
  initial begin
    do_reset(1'b1);
    for (int i = 0; i < 3; i++) op(1'b0, 1'b1, 8'(8'hA9 + i), 8'h00);
    // every source masked: both outputs must read good whatever the rails do
    for (int i = 0; i < 3; i++) op(1'b1, 1'b0, 8'(8'hA9 + i), `PGT_ALL_ONES);
    for (int i = 0; i < 3; i++) op(1'b0, 1'b1, 8'(8'hA9 + i), 8'h00);
    // A8 stands in for an unmapped neighbour
    for (int i = 0; i < 1200; i++) begin
      if (i == 600) do_reset(1'b0);
      seed = xs(seed);
      op(seed[0], seed[1] & ~seed[0], 8'hA8 + {6'h00, seed[5:4]}, seed[15:8]);
    end
    repeat (2) op(1'b0, 1'b0, 8'h00, 8'h00);
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule : pgt_masks_bench
`default_nettype wire
